//--- gpbp_params.svh
// Register indices, field positions and reset values of the six-pin port
`ifndef GPBP_PARAMS_SVH
`define GPBP_PARAMS_SVH
`define GPBP_NPINS        6
`define GPBP_AW           12
`define GPBP_DW           32
`define GPBP_IDX_DATA     8'h05
`define GPBP_IDX_OPT      8'h81
`define GPBP_IDX_DIR      8'h85
`define GPBP_IDX_ANA      8'h91
`define GPBP_IDX_PULL     8'h95
`define GPBP_IDX_CFG      8'ha0
`define GPBP_OPT_PU_DIS   7
`define GPBP_CFG_MASTER_CLEAR_PIN_ENABLE    0
`define GPBP_CFG_XTAL     1
`define GPBP_PIN3         3
`define GPBP_RST_DIR      6'h3f
`define GPBP_RST_PULL     6'h37
`define GPBP_RST_LATCH    6'h00
`define GPBP_RST_ANA      6'h00
`define GPBP_RST_OPT      8'h80
`define GPBP_RST_CFG      2'h0
`define GPBP_XTAL_PINS    6'h30
`define GPBP_PULL_MASK    6'h37
`endif

//--- gpbp_pkg.sv
// Types shared by the six-pin port
package gpbp_pkg;
  typedef enum logic [2:0] {
    GPBP_SEL_NONE = 3'b000,
    GPBP_SEL_DATA = 3'b001,
    GPBP_SEL_DIR  = 3'b010,
    GPBP_SEL_PULL = 3'b011,
    GPBP_SEL_OPT  = 3'b100,
    GPBP_SEL_ANA  = 3'b101,
    GPBP_SEL_CFG  = 3'b110
  } gpbp_sel_t;
  typedef enum logic [1:0] {
    GPBP_APB_IDLE = 2'b00,
    GPBP_APB_WAIT = 2'b01,
    GPBP_APB_DONE = 2'b10
  } gpbp_apb_t;
endpackage : gpbp_pkg

//--- gpbp_sync.sv
// Two-flop synchroniser for the pin input levels
`include "gpbp_params.svh"
module gpbp_sync (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic [`GPBP_NPINS-1:0]  din,
  output logic      [`GPBP_NPINS-1:0]  dout
);
  logic [`GPBP_NPINS-1:0] meta_reg;
  logic [`GPBP_NPINS-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= 6'h00;
      sync_reg <= 6'h00;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;
endmodule : gpbp_sync

//--- gpbp_port.sv
// Six-pin bidirectional port with weak pull-ups behind an APB slave
// Overview of operation
// [RULE1] Six general-purpose pins, each with its own direction bit.
// [RULE2] Direction bit one tri-states the pin driver; pin is input.
// [RULE3] Direction bit zero drives the output latch onto the pin.
// [RULE4] Pin 3 is input only; its direction bit always reads one.
// [RULE5] Data reads return pin levels; data writes update the output latch.
// [RULE6] Writes are read-modify-write: unwritten bits take the sensed pin levels.
// [RULE7] Pin 3 data reads zero while master clear pin is enabled.
// [RULE8] Direction still rules analog pins; analog pins read zero.
// [RULE9] Software keeps analog pins set as inputs.
// [RULE10] Software sets analog select and comparator control before digital use.
// [RULE11] An enabled sharing peripheral takes its pin away from the port.
// [RULE12] Every pin but pin 3 has a per-pin weak pull-up enable.
// [RULE13] Pull-up is forced off while the pin is an output.
// [RULE14] Power-on reset disables all pull-ups via option bit 7.
// [RULE15] Pin 3 pull-up follows master clear enable; no software control.
// [RULE16] Data bits 7 and 6 read zero; bits 5..0 are pins 5..0.
// [RULE17] Per-pin pull-up acts only while global pull-up control permits.
// [RULE18] Crystal oscillator mode makes direction bits 5 and 4 read one.
// [RULE19] Active pull-up is global permit AND enable AND input direction.
// [RULE20] Pin levels are synchronised to the core clock before reads.
`include "gpbp_params.svh"
module gpbp_port (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`GPBP_AW-1:0]     paddr,
  input  wire logic [`GPBP_DW-1:0]     pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [`GPBP_DW-1:0]     prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [`GPBP_NPINS-1:0]  pin_in,
  output logic      [`GPBP_NPINS-1:0]  pin_out,
  output logic      [`GPBP_NPINS-1:0]  pin_oe,
  output logic      [`GPBP_NPINS-1:0]  pin_pullup,
  input  wire logic [`GPBP_NPINS-1:0]  periph_en,
  input  wire logic [`GPBP_NPINS-1:0]  periph_out,
  input  wire logic [`GPBP_NPINS-1:0]  periph_oe
);
  logic [`GPBP_NPINS-1:0] pin_sync;
  logic [`GPBP_NPINS-1:0] latch_reg;
  logic [`GPBP_NPINS-1:0] latch_next;
  logic [`GPBP_NPINS-1:0] dir_reg;
  logic [`GPBP_NPINS-1:0] pull_reg;
  logic [`GPBP_NPINS-1:0] ana_reg;
  logic [7:0]             opt_reg;
  logic [1:0]             cfg_reg;
  logic [`GPBP_DW-1:0]    prdata_reg;
  logic [`GPBP_DW-1:0]    prdata_next;
  logic                   pslverr_reg;
  logic                   pready_reg;
  logic [`GPBP_NPINS-1:0] pin_out_reg;
  logic [`GPBP_NPINS-1:0] pin_oe_reg;
  logic [`GPBP_NPINS-1:0] pull_act_reg;
  gpbp_pkg::gpbp_apb_t    apb_reg;
  gpbp_pkg::gpbp_apb_t    apb_next;
  gpbp_pkg::gpbp_sel_t    sel;

  function automatic logic reg_hit(input logic [`GPBP_AW-1:0] addr, input logic [7:0] idx);
    reg_hit = (addr == {2'b00, idx, 2'b00});
  endfunction : reg_hit

  // [RULE20] Pin synchroniser
  gpbp_sync u_sync (
    .clk    (clk),
    .resetn (resetn),
    .din    (pin_in),
    .dout   (pin_sync)
  );

  // Address decode
  always_comb begin
    if (reg_hit(paddr, `GPBP_IDX_DATA)) begin
      sel = gpbp_pkg::GPBP_SEL_DATA;
    end else if (reg_hit(paddr, `GPBP_IDX_DIR)) begin
      sel = gpbp_pkg::GPBP_SEL_DIR;
    end else if (reg_hit(paddr, `GPBP_IDX_PULL)) begin
      sel = gpbp_pkg::GPBP_SEL_PULL;
    end else if (reg_hit(paddr, `GPBP_IDX_OPT)) begin
      sel = gpbp_pkg::GPBP_SEL_OPT;
    end else if (reg_hit(paddr, `GPBP_IDX_ANA)) begin
      sel = gpbp_pkg::GPBP_SEL_ANA;
    end else if (reg_hit(paddr, `GPBP_IDX_CFG)) begin
      sel = gpbp_pkg::GPBP_SEL_CFG;
    end else begin
      sel = gpbp_pkg::GPBP_SEL_NONE;
    end
  end

  wire master_clear_pin_enable    = cfg_reg[`GPBP_CFG_MASTER_CLEAR_PIN_ENABLE];
  wire xtal     = cfg_reg[`GPBP_CFG_XTAL];
  wire pu_allow = ~opt_reg[`GPBP_OPT_PU_DIS];
  wire mapped   = (sel != gpbp_pkg::GPBP_SEL_NONE);
  // One wait state: request taken in setup, answer on second access cycle
  wire access   = psel & penable & (apb_reg == gpbp_pkg::GPBP_APB_WAIT);
  wire wr_en    = psel & penable & pwrite & (apb_reg == gpbp_pkg::GPBP_APB_DONE) & mapped;
  wire byte0    = pstrb[0];

  // [RULE4] Pin 3 forced to input; [RULE18] crystal pins forced to input
  wire [`GPBP_NPINS-1:0] dir_eff = dir_reg | 6'h08 | (xtal ? `GPBP_XTAL_PINS : 6'h00);

  // [RULE7] Pin 3 reads zero under master clear; [RULE8] analog reads zero
  wire [`GPBP_NPINS-1:0] pin3_mask = master_clear_pin_enable ? 6'h08 : 6'h00;
  wire [`GPBP_NPINS-1:0] data_rd   = pin_sync & ~ana_reg & ~pin3_mask;

  // [RULE12] Pull-up enables exist on all pins but pin 3
  wire [`GPBP_NPINS-1:0] pull_rd   = (pull_reg & `GPBP_PULL_MASK) |
                                     (xtal ? `GPBP_XTAL_PINS : 6'h00);

  // [RULE13] Output mode kills pull-up; [RULE17] [RULE19] global permit gates
  wire [`GPBP_NPINS-1:0] pull_dig  = (pu_allow ? pull_reg : 6'h00) & dir_eff &
                                     `GPBP_PULL_MASK;
  // [RULE15] Pin 3 pull-up tracks master clear only
  wire [`GPBP_NPINS-1:0] pull_act  = pull_dig | pin3_mask;

  // [RULE11] Enabled peripheral owns its pin
  // [RULE2] [RULE3] [RULE8] Direction drives or tri-states every pin not taken by a peripheral
  wire [`GPBP_NPINS-1:0] oe_next   = (periph_en & periph_oe) | (~periph_en & ~dir_eff);
  wire [`GPBP_NPINS-1:0] out_next  = (periph_en & periph_out) | (~periph_en & latch_reg);

  // [RULE5] [RULE16] Read mux, bits above pins read zero except the 8-bit option register
  always_comb begin
    prdata_next = 32'h0000_0000;
    case (sel)
      gpbp_pkg::GPBP_SEL_DATA: prdata_next = {26'h0, data_rd};
      gpbp_pkg::GPBP_SEL_DIR:  prdata_next = {26'h0, dir_eff};
      gpbp_pkg::GPBP_SEL_PULL: prdata_next = {26'h0, pull_rd};
      gpbp_pkg::GPBP_SEL_OPT:  prdata_next = {24'h0, opt_reg};
      gpbp_pkg::GPBP_SEL_ANA:  prdata_next = {26'h0, ana_reg};
      gpbp_pkg::GPBP_SEL_CFG:  prdata_next = {30'h0, cfg_reg};
      default:                 prdata_next = 32'h0000_0000;
    endcase
  end

  // [RULE6] Read-modify-write: unstrobed bits reload from the sensed pins
  assign latch_next = byte0 ? pwdata[`GPBP_NPINS-1:0] : pin_sync;

  always_comb begin
    apb_next = apb_reg;
    case (apb_reg)
      gpbp_pkg::GPBP_APB_IDLE: begin
        if (psel && !penable) begin
          apb_next = gpbp_pkg::GPBP_APB_WAIT;
        end
      end
      gpbp_pkg::GPBP_APB_WAIT: begin
        if (psel && penable) begin
          apb_next = gpbp_pkg::GPBP_APB_DONE;
        end
      end
      gpbp_pkg::GPBP_APB_DONE: begin
        apb_next = gpbp_pkg::GPBP_APB_IDLE;
      end
      default: apb_next = gpbp_pkg::GPBP_APB_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      apb_reg     <= gpbp_pkg::GPBP_APB_IDLE;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
      pready_reg  <= 1'b0;
    end else begin
      apb_reg <= apb_next;
      // Ready straight from a flop, high exactly while the state is done
      pready_reg <= (apb_next == gpbp_pkg::GPBP_APB_DONE);
      if (access) begin
        prdata_reg  <= pwrite ? 32'h0000_0000 : prdata_next;
        pslverr_reg <= ~mapped;
      end
    end
  end

  // [RULE14] Pull-ups disabled at power-on via option bit 7
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latch_reg <= `GPBP_RST_LATCH;
      dir_reg   <= `GPBP_RST_DIR;
      pull_reg  <= `GPBP_RST_PULL;
      ana_reg   <= `GPBP_RST_ANA;
      opt_reg   <= `GPBP_RST_OPT;
      cfg_reg   <= `GPBP_RST_CFG;
    end else if (wr_en) begin
      // [RULE5] Data write lands in the latch
      if (sel == gpbp_pkg::GPBP_SEL_DATA) begin
        latch_reg <= latch_next;
      end
      if (byte0 && sel == gpbp_pkg::GPBP_SEL_DIR) begin
        dir_reg <= pwdata[`GPBP_NPINS-1:0];
      end
      if (byte0 && sel == gpbp_pkg::GPBP_SEL_PULL) begin
        pull_reg <= pwdata[`GPBP_NPINS-1:0] & `GPBP_PULL_MASK;
      end
      if (byte0 && sel == gpbp_pkg::GPBP_SEL_OPT) begin
        opt_reg <= pwdata[7:0];
      end
      if (byte0 && sel == gpbp_pkg::GPBP_SEL_ANA) begin
        ana_reg <= pwdata[`GPBP_NPINS-1:0];
      end
      if (byte0 && sel == gpbp_pkg::GPBP_SEL_CFG) begin
        cfg_reg <= pwdata[1:0];
      end
    end
  end

  // [RULE1] Pin drivers registered, tri-state off at reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_out_reg  <= 6'h00;
      pin_oe_reg   <= 6'h00;
      pull_act_reg <= 6'h00;
    end else begin
      pin_out_reg  <= out_next;
      pin_oe_reg   <= oe_next;
      pull_act_reg <= pull_act;
    end
  end

  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign pin_out    = pin_out_reg;
  assign pin_oe     = pin_oe_reg;
  assign pin_pullup = pull_act_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // [RULE2] Input direction tri-states
  dir_input_a: assert property (dir_reg[0] && !periph_en[0] |=> !pin_oe[0]) // [RULE2]
    else $error("Input pin still driven");

  // [RULE3] Output drives the latch
  dir_output_a: assert property (!dir_reg[1] && !periph_en[1] |=> pin_oe[1] && // [RULE3]
    pin_out[1] == $past(latch_reg[1]))
    else $error("Output pin not driving latch");

  // [RULE4] Pin 3 never driven by the port
  pin3_hiz_a: assert property (!periph_en[3] |=> !pin_oe[3]) // [RULE4]
    else $error("Pin 3 driven as output");

  // [RULE7] Pin 3 data masked under master clear
  pin3_read_a: assert property (access && !pwrite && sel == gpbp_pkg::GPBP_SEL_DATA && // [RULE7]
    master_clear_pin_enable |=> prdata[3] == 1'b0)
    else $error("Pin 3 reads one with master clear");

  // [RULE8] Analog pins read zero
  ana_read_a: assert property (access && !pwrite && sel == gpbp_pkg::GPBP_SEL_DATA // [RULE8]
    |=> (prdata[5:0] & $past(ana_reg)) == 6'h00)
    else $error("Analog pin reads one");

  // [RULE13] No pull-up on driving pin
  pull_out_a: assert property (!dir_eff[0] |=> !pin_pullup[0]) // [RULE13]
    else $error("Pull-up on output pin");

  // [RULE19] Pull-up equation
  pull_eq_a: assert property (##1 pin_pullup[2] == $past(pu_allow && pull_reg[2] && // [RULE19]
    dir_eff[2]))
    else $error("Pull-up mismatch on pin 2");

  // [RULE15] Pin 3 pull-up tracks master clear
  pin3_pull_a: assert property (##1 pin_pullup[3] == $past(master_clear_pin_enable)) // [RULE15]
    else $error("Pin 3 pull-up wrong");

  // [RULE16] Upper data bits zero
  data_upper_a: assert property (pready && !pslverr |-> prdata[31:8] == 24'h0) // [RULE16]
    else $error("Upper read bits not zero");

  // [RULE18] Crystal pins not driven as outputs
  xtal_dir_a: assert property (xtal && !periph_en[5] && !periph_en[4] |=> // [RULE18]
    pin_oe[5:4] == 2'b00)
    else $error("Crystal pins still driven");

  // [RULE4] Direction read shows pin 3 as input
  dir_read_a: assert property (access && !pwrite && sel == gpbp_pkg::GPBP_SEL_DIR // [RULE4]
    |=> prdata[3] == 1'b1)
    else $error("Pin 3 direction reads zero");

  // [RULE5] Strobed data write lands in latch
  data_latch_a: assert property (wr_en && sel == gpbp_pkg::GPBP_SEL_DATA && byte0 // [RULE5]
    |=> latch_reg == $past(pwdata[`GPBP_NPINS-1:0]))
    else $error("Data write missed the latch");

  // [RULE17] Global control blocks pull-ups
  pull_glob_a: assert property (!pu_allow |=> // [RULE17]
    (pin_pullup & `GPBP_PULL_MASK) == 6'h00)
    else $error("Pull-up on while globally disabled");

  // [RULE3] Pin 4 drives latch as output
  pin4_drive_a: assert property (!dir_eff[4] && !periph_en[4] |=> pin_oe[4] && // [RULE3]
    pin_out[4] == $past(latch_reg[4]))
    else $error("Pin 4 not driving latch");

  // [RULE6] Data write without strobe reloads pin levels
  rmw_write_a: assert property (wr_en && sel == gpbp_pkg::GPBP_SEL_DATA && !byte0 // [RULE6]
    |=> latch_reg == $past(pin_sync))
    else $error("Read-modify-write lost pin levels");

  // [RULE11] Peripheral owns the pin
  periph_own_a: assert property (periph_en[0] |=> pin_oe[0] == $past(periph_oe[0]) && // [RULE11]
    pin_out[0] == $past(periph_out[0]))
    else $error("Peripheral did not take pin 0");
endmodule : gpbp_port

//--- gpbp_pins.sv
// Model of the outside circuitry that resolves each pin level
module gpbp_pins (
  input  wire logic       clk,
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] pin_pullup,
  input  wire logic [5:0] ext_drv,
  input  wire logic [5:0] ext_val,
  output logic      [5:0] level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tog;
  initial tog = 1'b0;
  // Undriven pins wander, so a stale level never reads as valid
  always @(posedge clk) tog <= ~tog;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pin_oe[i] && ext_drv[i]) level[i] = 1'bx;
      else if (pin_oe[i]) level[i] = pin_out[i];
      else if (ext_drv[i]) level[i] = ext_val[i];
      else if (pin_pullup[i]) level[i] = 1'b1;
      else level[i] = tog;
    end
  end
endmodule : gpbp_pins

//--- gpbp_port_tb.sv
// Self-checking bench for the six-pin port
module gpbp_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [11:0] a;
    logic        w;
    logic [31:0] d;
    logic [31:0] e;
    logic        er;
  } gpbp_row_t;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic [5:0]  pin_in, pin_out, pin_oe, pin_pullup;
  logic [5:0]  periph_en, periph_out, periph_oe, ext_drv, ext_val;
  logic        er;
  int          bad_count, total_checks;
  gpbp_row_t   rows[19] = '{
    '{12'h214, 1'b0, 32'h0, 32'h3f, 1'b0},
    '{12'h254, 1'b0, 32'h0, 32'h37, 1'b0},
    '{12'h204, 1'b0, 32'h0, 32'h80, 1'b0},
    '{12'h280, 1'b0, 32'h0, 32'h00, 1'b0},
    '{12'h244, 1'b0, 32'h0, 32'h00, 1'b0},
    '{12'h214, 1'b1, 32'h0, 32'h00, 1'b0},
    '{12'h214, 1'b0, 32'h0, 32'h08, 1'b0},
    '{12'h014, 1'b1, 32'hd5, 32'h0, 1'b0},
    '{12'h014, 1'b0, 32'h0, 32'h1d, 1'b0},
    '{12'h280, 1'b1, 32'h1, 32'h00, 1'b0},
    '{12'h014, 1'b0, 32'h0, 32'h15, 1'b0},
    '{12'h214, 1'b1, 32'h1, 32'h00, 1'b0},
    '{12'h244, 1'b1, 32'h1, 32'h00, 1'b0},
    '{12'h014, 1'b0, 32'h0, 32'h14, 1'b0},
    '{12'h244, 1'b1, 32'h0, 32'h00, 1'b0},
    '{12'h214, 1'b1, 32'h0, 32'h00, 1'b0},
    '{12'h280, 1'b1, 32'h0, 32'h00, 1'b0},
    '{12'h300, 1'b0, 32'h0, 32'h00, 1'b1},
    '{12'h300, 1'b1, 32'hff, 32'h0, 1'b1}
  };
  gpbp_port dut_u (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .periph_en(periph_en), .periph_out(periph_out), .periph_oe(periph_oe));
  gpbp_pins pins_u (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_drv(ext_drv), .ext_val(ext_val), .level(pin_in));
  always #10 clk = ~clk;
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Bus master: holds the request until pready is seen at an edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 4'h1);
  endtask : wr
  // Reads wait first so the two-flop pin synchroniser has settled
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    repeat (3) @(posedge clk);
    apb(a, 1'b0, 32'h0, 4'h1);
    chk(q, e);
  endtask : rd
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask : settle
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    $display("watchdog expired");
    print_verdict();
  end
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    {periph_en, periph_out, periph_oe} = 18'h0;
    ext_drv = 6'h08;
    ext_val = 6'h08;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    settle();
    chk(32'(pin_oe), 32'h0);
    chk(32'(pin_pullup), 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      if (!rows[i].w) repeat (3) @(posedge clk);
      apb(rows[i].a, rows[i].w, rows[i].d, 4'h1);
      chk(q, rows[i].e);
      chk(32'(er), 32'(rows[i].er));
    end
    $display("table test done");
    wr(12'h204, 32'h0);
    wr(12'h214, 32'h3f);
    settle();
    chk(32'(pin_pullup), 32'h37);
    wr(12'h214, 32'h3c);
    settle();
    chk(32'(pin_pullup), 32'h34);
    wr(12'h280, 32'h1);
    settle();
    chk(32'(pin_pullup), 32'h3c);
    wr(12'h280, 32'h0);
    wr(12'h204, 32'h80);
    settle();
    chk(32'(pin_pullup), 32'h0);
    $display("pull-up test done");
    wr(12'h214, 32'h3f);
    ext_drv <= 6'h3f;
    ext_val <= 6'h2a;
    settle();
    apb(12'h014, 1'b1, 32'h3f, 4'h0);
    ext_drv <= 6'h08;
    wr(12'h214, 32'h0);
    settle();
    chk(32'(pin_oe), 32'h37);
    chk(32'(pin_out & 6'h37), 32'h22);
    apb(12'h214, 1'b1, 32'h3f, 4'h0);
    rd(12'h214, 32'h08);
    $display("read-modify-write test done");
    wr(12'h280, 32'h2);
    settle();
    chk(32'(pin_oe), 32'h07);
    rd(12'h214, 32'h38);
    wr(12'h280, 32'h0);
    $display("crystal test done");
    @(posedge clk);
    periph_en <= 6'h01;
    periph_oe <= 6'h01;
    periph_out <= 6'h01;
    settle();
    chk(32'(pin_out & 6'h37), 32'h23);
    $display("peripheral test done");
    @(posedge clk);
    resetn <= 1'b0;
    periph_en <= 6'h00;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    settle();
    chk(32'(pin_oe), 32'h0);
    chk(32'(pin_pullup), 32'h0);
    rd(12'h214, 32'h3f);
    rd(12'h204, 32'h80);
    $display("mid-run reset test done");
    print_verdict();
  end
endmodule : gpbp_port_tb
